// File: design/tlo_line_out.sv
// Transmit line output stage of one port: line clock, rails, data and analog pins.
// Assumes foreign clocks arrive as plain inputs and are sampled by pclk; rail data
// comes from an encoder on pclk and is taken on the pulse bit_take.
`timescale 1ns/1ps
`default_nettype none
module tlo_line_out
   import tlo_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        line_clock_src,
   input  wire logic        tx_clock_output,
   input  wire logic        tx_clock_input,
   input  wire logic        rx_line_clock_input,
   input  wire logic        rx_clock_output,
   input  wire logic        enc_pos,
   input  wire logic        enc_neg,
   input  wire logic        enc_data,
   output logic             bit_take,
   output logic             tx_line_clock_out,
   output logic             tx_positive_rail,
   output logic             tx_negative_rail,
   output logic             tx_analog_plus,
   output logic             tx_analog_plus_oe_n,
   output logic             tx_analog_minus,
   output logic             tx_analog_minus_oe_n
);
   tlo_state_s q;
   tlo_state_s d;

   logic [NUM_CLKS-1:0] clk_pins;
   logic                ref_now;
   logic                ref_was;
   logic                upd_edge;
   logic                acc;
   logic                src_rise;
   logic [7:0]          min_cyc;
   logic [2:0]          sel;

   assign clk_pins = {rx_clock_output, rx_line_clock_input, tx_clock_input,
                      tx_clock_output, line_clock_src};

   always_comb
   begin
      d        = q;
      d.take   = 1'b0;
      // Codes above the last clock would index past the vector, so they fall back.
      sel      = (q.ctrl.refsel < 3'(NUM_CLKS)) ? q.ctrl.refsel : REF_LINE_CLK;
      ref_now  = q.sync.s2[sel];
      ref_was  = q.sync.prev[sel];
      upd_edge = q.ctrl.ref_inv ? (ref_was & ~ref_now) : (~ref_was & ref_now);
      src_rise = ~q.sync.prev[REF_LINE_CLK] & q.sync.s2[REF_LINE_CLK];
      min_cyc  = q.ctrl.e3 ? 8'(E3_MIN_CYC) : 8'(DS3_MIN_CYC);
      acc      = psel & penable & q.pready;

      // Two flops before any logic sees a foreign clock.
      d.sync.s1   = clk_pins;
      d.sync.s2   = q.sync.s1;
      d.sync.prev = q.sync.s2;

      // APB: the answer comes one cycle after setup, so every output is a flop.
      d.pready  = psel & ~penable;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
      if (psel & ~penable)
      begin
         unique case (paddr)
            CTRL_OFS:
            begin
               d.prdata[10:0] = q.ctrl;
            end
            STATUS_OFS:
            begin
               d.prdata[STAT_PERIOD_LO +: 8] = q.period;
               d.prdata[STAT_TOO_FAST]       = q.too_fast;
            end
            default:
            begin
               d.pslverr = 1'b1;
            end
         endcase
      end
      if (acc & pwrite & (paddr == CTRL_OFS))
      begin
         d.ctrl = pwdata[10:0];
      end

      // Bit period monitor; a fast line clock is flagged and the set wins over the clear.
      if (src_rise)
      begin
         d.period  = q.per_cnt;
         d.per_cnt = 8'h01;
      end
      else if (q.per_cnt != PERIOD_MAX)
      begin
         d.per_cnt = q.per_cnt + 8'h01;
      end
      if (acc & pwrite & (paddr == STATUS_OFS) & pwdata[STAT_TOO_FAST])
      begin
         d.too_fast = 1'b0;
      end
      if (src_rise & (q.per_cnt < min_cyc) & (q.period != 8'h00))
      begin
         d.too_fast = 1'b1;
      end

      // Line clock follows its source only while enabled.
      d.clk_out = q.ctrl.line_en ? (q.sync.s2[REF_LINE_CLK] ^ q.ctrl.out_inv)
                                 : 1'b0;

      // Rails clear while disabled and otherwise load only on the chosen reference edge.
      if (!q.ctrl.line_en)
      begin
         d.pos_out = 1'b0;
         d.neg_out = 1'b0;
      end
      else if (upd_edge)
      begin
         d.take = 1'b1;
         if (q.ctrl.single)
         begin
            d.pos_out = enc_data ^ q.ctrl.out_inv;
            d.neg_out = q.ctrl.out_inv;
         end
         else
         begin
            d.pos_out = enc_pos ^ q.ctrl.out_inv;
            d.neg_out = enc_neg ^ q.ctrl.out_inv;
         end
         d.aplus  = enc_pos & ~q.ctrl.single;
         d.aminus = enc_neg & ~q.ctrl.single;
      end
      // The data pin goes quiet at once, not only at the next reference edge.
      if (q.ctrl.xcvr_en & q.ctrl.dig_dis)
      begin
         d.pos_out = 1'b0;
      end
      // The analog pair floats unless both enables are set.
      d.aoe_n = ~(q.ctrl.xcvr_en & q.ctrl.drive_en);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q      <= '0;
         q.aoe_n <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign pready               = q.pready;
   assign prdata               = q.prdata;
   assign pslverr              = q.pslverr;
   assign bit_take             = q.take;
   assign tx_line_clock_out    = q.clk_out;
   assign tx_positive_rail     = q.pos_out;
   assign tx_negative_rail     = q.neg_out;
   assign tx_analog_plus       = q.aplus;
   assign tx_analog_minus      = q.aminus;
   assign tx_analog_plus_oe_n  = q.aoe_n;
   assign tx_analog_minus_oe_n = q.aoe_n;

   // Helper for assertions: the edge that was acted on in the previous cycle.
   logic edge_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edge_q <= 1'b0;
      end
      else
      begin
         edge_q <= upd_edge & q.ctrl.line_en;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   clk_gated_a: assert property (!q.ctrl.line_en |=> !tx_line_clock_out)
      else $error("line clock toggles while pins disabled");
   pins_hold_a: assert property (!q.ctrl.line_en ##1 !q.ctrl.line_en
      |-> !tx_positive_rail && !tx_negative_rail)
      else $error("rails not held while disabled");
   edge_only_a: assert property (q.ctrl.line_en && $past(q.ctrl.line_en)
      && $changed(tx_negative_rail) |-> edge_q)
      else $error("rail changed off the reference edge");
   pos_follow_a: assert property (upd_edge && q.ctrl.line_en && !q.ctrl.single
      && !(q.ctrl.xcvr_en && q.ctrl.dig_dis)
      |=> tx_positive_rail == ($past(enc_pos) ^ $past(q.ctrl.out_inv)))
      else $error("positive rail does not follow encoder");
   neg_follow_a: assert property (upd_edge && q.ctrl.line_en && !q.ctrl.single
      |=> tx_negative_rail == ($past(enc_neg) ^ $past(q.ctrl.out_inv)))
      else $error("negative rail does not follow encoder");
   uni_data_a: assert property (upd_edge && q.ctrl.line_en && q.ctrl.single
      && !(q.ctrl.xcvr_en && q.ctrl.dig_dis)
      |=> tx_positive_rail == ($past(enc_data) ^ $past(q.ctrl.out_inv)))
      else $error("single rail data not presented");
   take_edge_a: assert property (bit_take |-> edge_q)
      else $error("bit taken without selected reference edge");
   clk_invert_a: assert property (q.ctrl.line_en ##1 q.ctrl.line_en
      |-> tx_line_clock_out == ($past(q.sync.s2[0]) ^ $past(q.ctrl.out_inv)))
      else $error("line clock polarity wrong");
   dig_off_a: assert property (q.ctrl.xcvr_en && q.ctrl.dig_dis
      |=> !tx_positive_rail)
      else $error("digital data pin not disabled");
   drive_on_a: assert property (q.ctrl.xcvr_en && q.ctrl.drive_en
      |=> !tx_analog_plus_oe_n && !tx_analog_minus_oe_n)
      else $error("analog pins not driven");
   hiz_a: assert property (!(q.ctrl.xcvr_en && q.ctrl.drive_en)
      |=> tx_analog_plus_oe_n && tx_analog_minus_oe_n)
      else $error("analog pins driven without enable");
   fast_flag_a: assert property (src_rise && q.per_cnt < min_cyc && q.period != 8'h00
      |=> q.too_fast)
      else $error("fast line clock not flagged");

   // Helpers that name the register bus writes and the fast line clock edge for the checks below.
   logic wr_ctrl;
   logic wr_clear;
   logic fast_seen;
   assign wr_ctrl   = acc & pwrite & (paddr == CTRL_OFS);
   assign wr_clear  = acc & pwrite & (paddr == STATUS_OFS) & pwdata[STAT_TOO_FAST];
   assign fast_seen = src_rise & (q.per_cnt < min_cyc) & (q.period != 8'h00);

   ready_setup_a: assert property (
      psel && !penable
      |=> pready)
      else $error("no ready after setup");
   ready_one_a: assert property (
      pready
      |=> !pready)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property (
      pready
      |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   data_idle_a: assert property (
      !pready
      |-> prdata == 32'h0000_0000)
      else $error("read data outside access");
   err_map_a: assert property (
      psel && !penable && paddr != CTRL_OFS && paddr != STATUS_OFS
      |=> pslverr)
      else $error("unmapped address not refused");
   err_ok_a: assert property (
      psel && !penable && (paddr == CTRL_OFS || paddr == STATUS_OFS)
      |=> !pslverr)
      else $error("mapped address refused");
   ctrl_read_a: assert property (
      psel && !penable && paddr == CTRL_OFS
      |=> prdata[10:0] == $past(q.ctrl))
      else $error("control read back wrong");
   stat_read_a: assert property (
      psel && !penable && paddr == STATUS_OFS
      |=> prdata[7:0] == $past(q.period) && prdata[8] == $past(q.too_fast))
      else $error("status read back wrong");
   ctrl_write_a: assert property (
      wr_ctrl
      |=> q.ctrl == $past(pwdata[10:0]))
      else $error("control write lost");
   ctrl_keep_a: assert property (
      !wr_ctrl
      |=> $stable(q.ctrl))
      else $error("control changed without write");

   // The sticky flag: a clear only counts when no new fast edge arrives with it.
   flag_clear_a: assert property (
      wr_clear && !fast_seen
      |=> !q.too_fast)
      else $error("fast flag not cleared");
   flag_hold_a: assert property (
      q.too_fast && !wr_clear
      |=> q.too_fast)
      else $error("fast flag lost");
   per_sat_a: assert property (
      q.per_cnt == PERIOD_MAX && !src_rise
      |=> q.per_cnt == PERIOD_MAX)
      else $error("period counter wrapped");
   per_load_a: assert property (
      src_rise
      |=> q.per_cnt == 8'h01 && q.period == $past(q.per_cnt))
      else $error("period not captured");
   per_count_a: assert property (
      !src_rise && q.per_cnt != PERIOD_MAX
      |=> q.per_cnt == $past(q.per_cnt) + 8'h01)
      else $error("period counter stalled");

   take_gate_a: assert property (
      !q.ctrl.line_en
      |=> !bit_take)
      else $error("bit taken while pins disabled");
   take_gap_a: assert property (
      bit_take
      |=> !bit_take)
      else $error("bits taken on adjacent cycles");
   analog_pos_a: assert property (
      upd_edge && q.ctrl.line_en
      |=> tx_analog_plus == ($past(enc_pos) && !$past(q.ctrl.single)))
      else $error("analog plus does not follow encoder");
   analog_neg_a: assert property (
      upd_edge && q.ctrl.line_en
      |=> tx_analog_minus == ($past(enc_neg) && !$past(q.ctrl.single)))
      else $error("analog minus does not follow encoder");
   analog_hold_a: assert property (
      !(upd_edge && q.ctrl.line_en)
      |=> $stable(tx_analog_plus) && $stable(tx_analog_minus))
      else $error("analog level changed off the edge");
   uni_neg_a: assert property (
      upd_edge && q.ctrl.line_en && q.ctrl.single
      |=> tx_negative_rail == $past(q.ctrl.out_inv))
      else $error("negative rail not idle in single rail");
   pos_edge_a: assert property (
      q.ctrl.line_en && $past(q.ctrl.line_en) && !$past(q.ctrl.xcvr_en && q.ctrl.dig_dis)
      && $changed(tx_positive_rail) |-> edge_q)
      else $error("positive rail changed off the edge");
endmodule : tlo_line_out
`default_nettype wire

// File: shared/tlo_pkg.sv
// Package of the transmit line output stage: register map, field layout and timing.
// Assumes a single 125 MHz register clock and APB with 32-bit data.
`default_nettype none
package tlo_pkg;
   // Register byte offsets.
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;

   // Control field positions.
   localparam int CTRL_LINE_EN   = 0;
   localparam int CTRL_SINGLE    = 1;
   localparam int CTRL_REFSEL_LO = 2;
   localparam int CTRL_REF_INV   = 5;
   localparam int CTRL_OUT_INV   = 6;
   localparam int CTRL_XCVR_EN   = 7;
   localparam int CTRL_DRIVE_EN  = 8;
   localparam int CTRL_DIG_DIS   = 9;
   localparam int CTRL_E3        = 10;
   localparam logic [10:0] CTRL_RESET = 11'h000;

   // Status field positions.
   localparam int STAT_PERIOD_LO = 0;
   localparam int STAT_TOO_FAST  = 8;

   // Reference clock choices, indices into the sampled clock vector.
   localparam logic [2:0] REF_LINE_CLK  = 3'h0;
   localparam logic [2:0] REF_TX_CLKO   = 3'h1;
   localparam logic [2:0] REF_TX_CLKI   = 3'h2;
   localparam logic [2:0] REF_RX_LINE   = 3'h3;
   localparam logic [2:0] REF_RX_CLKO   = 3'h4;
   localparam int         NUM_CLKS      = 5;

   // Line rates and the shortest legal bit period in register clock cycles.
   localparam int PCLK_KHZ      = 125000;
   localparam int DS3_RATE_KHZ  = 44736;
   localparam int E3_RATE_KHZ   = 34368;
   localparam int RATE_PPM      = 20;
   localparam int DS3_MIN_CYC   = (PCLK_KHZ * 1000) / (DS3_RATE_KHZ * (1000 + RATE_PPM) / 1000) / 1000;
   localparam int E3_MIN_CYC    = (PCLK_KHZ * 1000) / (E3_RATE_KHZ * (1000 + RATE_PPM) / 1000) / 1000;
   localparam logic [7:0] PERIOD_MAX = 8'hff;

   typedef struct packed {
      logic       e3;
      logic       dig_dis;
      logic       drive_en;
      logic       xcvr_en;
      logic       out_inv;
      logic       ref_inv;
      logic [2:0] refsel;
      logic       single;
      logic       line_en;
   } tlo_ctrl_s;

   typedef struct packed {
      logic pos;
      logic neg;
      logic data;
   } tlo_bits_s;

   typedef struct packed {
      logic [NUM_CLKS-1:0] s1;
      logic [NUM_CLKS-1:0] s2;
      logic [NUM_CLKS-1:0] prev;
   } tlo_sync_s;

   typedef struct packed {
      tlo_ctrl_s   ctrl;
      tlo_sync_s   sync;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        clk_out;
      logic        pos_out;
      logic        neg_out;
      logic        aplus;
      logic        aminus;
      logic        aoe_n;
      logic        take;
      logic [7:0]  per_cnt;
      logic [7:0]  period;
      logic        too_fast;
   } tlo_state_s;
endpackage : tlo_pkg
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the transmit line output stage.
// Assumes the far-side clock model and an APB master built here.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tlo_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        enc_pos, enc_neg, enc_data, bit_take, lco, pos, neg, ap, am, apoe, amoe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  run, clks;
   int          fails = 0, checked = 0, cyc = 0, n;

   tlo_line_out tlo_line_out_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .line_clock_src(clks[0]),
      .tx_clock_output(clks[1]), .tx_clock_input(clks[2]), .rx_line_clock_input(clks[3]),
      .rx_clock_output(clks[4]), .enc_pos(enc_pos), .enc_neg(enc_neg), .enc_data(enc_data),
      .bit_take(bit_take), .tx_line_clock_out(lco), .tx_positive_rail(pos),
      .tx_negative_rail(neg), .tx_analog_plus(ap), .tx_analog_plus_oe_n(apoe),
      .tx_analog_minus(am), .tx_analog_minus_oe_n(amoe));
   tlo_far_end tlo_far_end_inst (.run(run), .clks(clks));

   task automatic test_done();
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask : chk

   // The request stands until pready is sampled high at a rising edge; data is taken there.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Offers encoder bits, waits for them to be taken and checks edge and rails.
   task automatic step(input int k, input logic lvl, input logic [2:0] e, input logic [1:0] r);
      @(posedge pclk);
      {enc_pos, enc_neg, enc_data} <= e;
      do
      begin
         @(posedge pclk);
         #1;
      end
      while (bit_take !== 1'b1);
      chk("ref", 32'(lvl), 32'(clks[k]));
      chk("rails", 32'(r), 32'({pos, neg}));
   endtask : step

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         test_done();
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, enc_pos, enc_neg, enc_data} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      run = 5'h01;
      repeat (2) @(posedge pclk);
      t_reset();
      t_dual();
      t_single();
      t_invert();
      t_refsel();
      t_analog();
      t_midreset();
      t_idle();
      test_done();
   end

   task automatic t_reset();
      chk("reset", 32'h3, 32'({lco, pos, neg, apoe, amoe}));
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped", 32'h1, rd | 32'(err));
   endtask : t_reset

   task automatic t_dual();
      apb(1'b1, CTRL_OFS, 32'h1);
      step(0, 1'b1, 3'b100, 2'b10);
      chk("lclk", 32'(clks[0]), 32'(lco));
      step(0, 1'b1, 3'b010, 2'b01);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status", 32'h14, rd);
   endtask : t_dual

   task automatic t_single();
      apb(1'b1, CTRL_OFS, 32'h3);
      step(0, 1'b1, 3'b001, 2'b10);
      step(0, 1'b1, 3'b110, 2'b00);
   endtask : t_single

   task automatic t_invert();
      apb(1'b1, CTRL_OFS, 32'h43);
      step(0, 1'b1, 3'b001, 2'b01);
      chk("lclk_inv", 32'({~clks[0]}), 32'(lco));
      apb(1'b1, CTRL_OFS, 32'h41);
      step(0, 1'b1, 3'b100, 2'b01);
   endtask : t_invert

   task automatic t_refsel();
      for (int k = 0; k < 5; k++)
      begin
         run <= 5'(1 << k);
         apb(1'b1, CTRL_OFS, 32'(1 + 4 * k + 32 * (k % 2)));
         step(k, k % 2 == 0, 3'b100, 2'b10);
      end
      run <= 5'h01;
   endtask : t_refsel

   task automatic t_analog();
      apb(1'b1, CTRL_OFS, 32'h181);
      step(0, 1'b1, 3'b100, 2'b10);
      chk("analog", 32'h8, 32'({ap, am, apoe, amoe}));
      apb(1'b1, CTRL_OFS, 32'h281);
      step(0, 1'b1, 3'b100, 2'b00);
      chk("hiz", 32'h3, 32'({apoe, amoe}));
      apb(1'b1, CTRL_OFS, 32'h101);
      step(0, 1'b1, 3'b100, 2'b10);
      chk("hiz_drv", 32'h3, 32'({apoe, amoe}));
   endtask : t_analog

   // A reset in mid-run must drop the pins and clear the control word.
   task automatic t_midreset();
      apb(1'b1, CTRL_OFS, 32'h1c1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      chk("rst_pins", 32'h3, 32'({lco, pos, neg, apoe, amoe}));
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("rst_ctrl", 32'h0, rd);
   endtask : t_midreset

   // Inversion stays on here: disabled pins must not show the inverted level.
   task automatic t_idle();
      apb(1'b1, CTRL_OFS, 32'h40);
      n = 0;
      repeat (60)
      begin
         @(posedge pclk);
         #1;
         n += int'({bit_take, pos, neg, lco} != 4'h0);
      end
      chk("idle", 32'h0, 32'(n));
   endtask : t_idle
endmodule : tb
`default_nettype wire

// File: sim/tlo_far_end.sv
// Far-side model: the five reference clocks of the line unit side.
// Assumes the bench enables the clock that it has selected.
`timescale 1ns/1ps
`default_nettype none
module tlo_far_end
   import tlo_pkg::*;
(
   input  wire logic [4:0] run,
   output logic [4:0]      clks
);
   // The odd start offset keeps the clock edges off the pclk edges.
   initial
   begin
      clks = 5'h00;
      #3;
      forever #80 clks = clks ^ run;
   end
endmodule : tlo_far_end
`default_nettype wire
